// ===== port_defs_driver.sv
// shared constants and structs, plus the per-bit pin drive stage
// assumes one clock domain; pin wire levels are resolved by the bench
`timescale 1ns/1ps

package port_defs_type_pkg;

   // ****************************************
   // register offsets (byte addresses)
   // ****************************************
   localparam logic [7:0] OFS_INDEX  = 8'h00;
   localparam logic [7:0] OFS_ACC    = 8'h04;
   localparam logic [7:0] OFS_CMD    = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;
   localparam logic [7:0] OFS_PINS   = 8'h10;

   // ****************************************
   // operation codes in the command register
   // ****************************************
   localparam logic [1:0] OP_READ  = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_SET   = 2'h2;
   localparam logic [1:0] OP_CLEAR = 2'h3;

   // ****************************************
   // default index codes for whole-port and bit operations
   // ****************************************
   localparam logic [3:0] DEF_SEL_IN    = 4'h0;
   localparam logic [3:0] DEF_SEL_CLK   = 4'h1;
   localparam logic [3:0] DEF_SEL_SHIFT = 4'h2;
   localparam logic [3:0] DEF_SEL_OUT   = 4'h8;
   localparam logic [3:0] DEF_SEL_PA    = 4'ha;
   localparam logic [3:0] DEF_SEL_PB    = 4'hb;
   localparam logic [1:0] DEF_BIT_OUT   = 2'h0;
   localparam logic [1:0] DEF_BIT_PA    = 2'h2;
   localparam logic [1:0] DEF_BIT_PB    = 2'h3;

   // ****************************************
   // field positions and reset values
   // ****************************************
   localparam int         CM_LO_BIT     = 1;
   localparam int         SM_LO_BIT     = 1;
   localparam int         SM_EDGE_BIT   = 3;
   localparam int         STAT_EDGE_BIT = 0;
   localparam int         OUT_IMPL_BITS = 3;
   localparam logic [1:0] CM_PIN_COUNT  = 2'h1;
   localparam logic [3:0] LATCH_RESET   = 4'h0;
   localparam logic [1:0] CM_RESET      = 2'h0;
   localparam logic [2:0] SM_RESET      = 3'h0;

   // ****************************************
   // drive styles
   // ****************************************
   localparam logic [1:0] STYLE_OD    = 2'h0;
   localparam logic [1:0] STYLE_PP    = 2'h1;
   localparam logic [1:0] STYLE_OD_PU = 2'h2;

   typedef struct packed {
      logic       cyc;
      logic       stb;
      logic       we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_type;

   typedef struct packed {
      logic [3:0] pin_in;
   } in_port_type;

   typedef struct packed {
      logic [3:0] pin_out;
      logic [3:0] pin_oe;
      logic [3:0] pull_up_en;
   } drive_type;

endpackage

module pin_drive
#(
   parameter int         WIDTH = 4,
   parameter logic [7:0] STYLE = 8'h55
)
(
   input  wire logic [WIDTH-1:0] latch,
   input  wire logic             driven,
   output logic      [WIDTH-1:0] pin_out,
   output logic      [WIDTH-1:0] pin_oe,
   output logic      [WIDTH-1:0] pull_up_en
);

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         if (STYLE[2*i +: 2] == port_defs_type_pkg::STYLE_PP)
         begin : g_pp
            // drives high and low once the port has been written
            assign pin_out[i]    = latch[i];
            assign pin_oe[i]     = driven;
            assign pull_up_en[i] = 1'b0;
         end
         else
         begin : g_od
            // a one in the latch releases the pull-down
            assign pin_out[i]    = 1'b0;
            assign pin_oe[i]     = driven & ~latch[i];
            assign pull_up_en[i] =
               (STYLE[2*i +: 2] == port_defs_type_pkg::STYLE_OD_PU);
         end
      end
   endgenerate

endmodule // pin_drive

// ===== quasi_bidir_port_logic.sv
// port logic of a small 4-bit controller behind a classic wishbone slave
// assumes pins synchronous to clk; the bench resolves wire levels
//
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/1ps

module quasi_bidir_port_logic
#(
   parameter logic [3:0] SEL_IN    = port_defs_type_pkg::DEF_SEL_IN,
   parameter logic [3:0] SEL_CLK   = port_defs_type_pkg::DEF_SEL_CLK,
   parameter logic [3:0] SEL_SHIFT = port_defs_type_pkg::DEF_SEL_SHIFT,
   parameter logic [3:0] SEL_OUT   = port_defs_type_pkg::DEF_SEL_OUT,
   parameter logic [3:0] SEL_PA    = port_defs_type_pkg::DEF_SEL_PA,
   parameter logic [3:0] SEL_PB    = port_defs_type_pkg::DEF_SEL_PB,
   parameter logic [1:0] BIT_OUT   = port_defs_type_pkg::DEF_BIT_OUT,
   parameter logic [1:0] BIT_PA    = port_defs_type_pkg::DEF_BIT_PA,
   parameter logic [1:0] BIT_PB    = port_defs_type_pkg::DEF_BIT_PB,
   parameter logic [5:0] OUT_STYLE = 6'h15,
   parameter logic [1:0] PA_STYLE  = port_defs_type_pkg::STYLE_OD_PU,
   parameter logic [1:0] PB_STYLE  = port_defs_type_pkg::STYLE_PP
)
(
   input  wire logic                           clk,
   input  wire logic                           rst,
   input  wire port_defs_type_pkg::wb_req_type wb_req,
   output logic      [31:0]                    dat_o,
   output logic                                ack_o,
   input  wire port_defs_type_pkg::in_port_type in_port,
   output logic      [2:0]                     out_port_pins_out,
   output logic      [2:0]                     out_port_pins_oe,
   input  wire logic [3:0]                     bidir_port_a_pins_in,
   output logic      [3:0]                     bidir_port_a_pins_out,
   output logic      [3:0]                     bidir_port_a_pins_oe,
   output logic      [3:0]                     bidir_port_a_pull_up,
   input  wire logic [3:0]                     bidir_port_b_pins_in,
   output logic      [3:0]                     bidir_port_b_pins_out,
   output logic      [3:0]                     bidir_port_b_pins_oe,
   output logic      [3:0]                     bidir_port_b_pull_up,
   output logic                                timer_count_clk,
   output logic                                count_src_sel_hi,
   output logic                                count_src_sel_lo,
   output logic                                edge_input_enable,
   output logic                                edge_test_input,
   output logic                                edge_request,
   output logic                                serial_func_sel_hi,
   output logic                                serial_func_sel_lo,
   output logic                                serial_clk_in,
   output logic                                serial_data_in
);

   // ****************************************
   // state
   // ****************************************
   typedef enum logic [1:0]
   {
      BUS_IDLE = 2'b01,
      BUS_ACK  = 2'b10
   } bus_state_type;

   typedef struct packed {
      bus_state_type bus;
      logic [31:0]   dat;
      logic [3:0]    idx;
      logic [3:0]    acc;
      logic [1:0]    cm;
      logic [2:0]    sm;
      logic [3:0]    out_latch;
      logic          out_driven;
      logic [3:0]    pa_latch;
      logic          pa_driven;
      logic [3:0]    pb_latch;
      logic          pb_driven;
      logic          pin0_prev;
      logic          edge_flag;
   } state_type;

   state_type s_reg;
   state_type s_next;

   logic       req;
   logic       commit;
   logic       cmd_go;
   logic [1:0] op;
   logic [3:0] pins;
   logic [3:0] bit_mask;
   logic       pin0_rise;
   logic [3:0] out_unused_out;
   logic [3:0] out_unused_oe;
   // output port has no pull-up, so its enable is left open

   assign pins      = in_port.pin_in;
   assign req       = wb_req.cyc & wb_req.stb;
   assign commit    = (s_reg.bus == BUS_ACK) & req & wb_req.we
                      & wb_req.sel[0];
   assign cmd_go    = commit & (wb_req.adr == port_defs_type_pkg::OFS_CMD);
   assign op        = wb_req.dat[1:0];
   assign bit_mask  = 4'h1 << s_reg.idx[1:0];
   assign pin0_rise = pins[0] & ~s_reg.pin0_prev;

   // ****************************************
   // next state
   // ****************************************
   always_comb
   begin
      s_next           = s_reg;
      s_next.pin0_prev = pins[0];
      // set beats a clear that lands in the same cycle
      if (commit && wb_req.adr == port_defs_type_pkg::OFS_STATUS
          && wb_req.dat[port_defs_type_pkg::STAT_EDGE_BIT])
         s_next.edge_flag = 1'b0;
      if (s_reg.sm[port_defs_type_pkg::SM_EDGE_BIT - 1] && pin0_rise)
         s_next.edge_flag = 1'b1;

      case (s_reg.bus)
         BUS_IDLE:
         begin
            if (req)
            begin
               s_next.bus = BUS_ACK;
               case (wb_req.adr)
                  port_defs_type_pkg::OFS_INDEX:
                     s_next.dat = {28'h0000000, s_reg.idx};
                  port_defs_type_pkg::OFS_ACC:
                     s_next.dat = {28'h0000000, s_reg.acc};
                  port_defs_type_pkg::OFS_STATUS:
                     s_next.dat = {31'h00000000, s_reg.edge_flag};
                  port_defs_type_pkg::OFS_PINS:
                     s_next.dat = {20'h00000, bidir_port_b_pins_in,
                                   bidir_port_a_pins_in, pins};
                  default:
                     s_next.dat = 32'h00000000;
               endcase
            end
         end
         BUS_ACK:
         begin
            // the write lands on the edge where the master sees ack
            s_next.bus = BUS_IDLE;
            if (commit && wb_req.adr == port_defs_type_pkg::OFS_INDEX)
               s_next.idx = wb_req.dat[3:0];
            if (commit && wb_req.adr == port_defs_type_pkg::OFS_ACC)
               s_next.acc = wb_req.dat[3:0];
            if (cmd_go)
            begin
               case (op)
                  port_defs_type_pkg::OP_READ:
                  begin
                     // latches untouched on any read
                     if (s_reg.idx == SEL_IN)
                        s_next.acc = pins;
                     else if (s_reg.idx == SEL_PA)
                        s_next.acc = bidir_port_a_pins_in;
                     else if (s_reg.idx == SEL_PB)
                        s_next.acc = bidir_port_b_pins_in;
                     else if (s_reg.idx == SEL_OUT)
                        s_next.acc = s_reg.out_latch;
                     else
                        s_next.acc = 4'h0;
                  end
                  port_defs_type_pkg::OP_WRITE:
                  begin
                     if (s_reg.idx == SEL_OUT)
                     begin
                        s_next.out_latch  = s_reg.acc;
                        s_next.out_driven = 1'b1;
                     end
                     else if (s_reg.idx == SEL_PA)
                     begin
                        s_next.pa_latch  = s_reg.acc;
                        s_next.pa_driven = 1'b1;
                     end
                     else if (s_reg.idx == SEL_PB)
                     begin
                        s_next.pb_latch  = s_reg.acc;
                        s_next.pb_driven = 1'b1;
                     end
                     else if (s_reg.idx == SEL_CLK)
                        s_next.cm = s_reg.acc[2:1];
                     else if (s_reg.idx == SEL_SHIFT)
                        s_next.sm = s_reg.acc[3:1];
                  end
                  port_defs_type_pkg::OP_SET,
                  port_defs_type_pkg::OP_CLEAR:
                  begin
                     // only the addressed bit moves
                     if (s_reg.idx[3:2] == BIT_OUT
                         && s_reg.idx[1:0] < 2'(port_defs_type_pkg::OUT_IMPL_BITS))
                     begin
                        s_next.out_latch  = (op == port_defs_type_pkg::OP_SET)
                           ? (s_reg.out_latch | bit_mask)
                           : (s_reg.out_latch & ~bit_mask);
                        s_next.out_driven = 1'b1;
                     end
                     else if (s_reg.idx[3:2] == BIT_PA)
                     begin
                        s_next.pa_latch  = (op == port_defs_type_pkg::OP_SET)
                           ? (s_reg.pa_latch | bit_mask)
                           : (s_reg.pa_latch & ~bit_mask);
                        s_next.pa_driven = 1'b1;
                     end
                     else if (s_reg.idx[3:2] == BIT_PB)
                     begin
                        s_next.pb_latch  = (op == port_defs_type_pkg::OP_SET)
                           ? (s_reg.pb_latch | bit_mask)
                           : (s_reg.pb_latch & ~bit_mask);
                        s_next.pb_driven = 1'b1;
                     end
                  end
                  default:
                     s_next.acc = s_reg.acc;
               endcase
            end
         end
         default:
            s_next.bus = BUS_IDLE;
      endcase
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         // latches clear to zero and drivers return to released state
         s_reg.bus        <= BUS_IDLE;
         s_reg.dat        <= 32'h00000000;
         s_reg.idx        <= 4'h0;
         s_reg.acc        <= 4'h0;
         s_reg.cm         <= port_defs_type_pkg::CM_RESET;
         s_reg.sm         <= port_defs_type_pkg::SM_RESET;
         s_reg.out_latch  <= port_defs_type_pkg::LATCH_RESET;
         s_reg.out_driven <= 1'b0;
         s_reg.pa_latch   <= port_defs_type_pkg::LATCH_RESET;
         s_reg.pa_driven  <= 1'b0;
         s_reg.pb_latch   <= port_defs_type_pkg::LATCH_RESET;
         s_reg.pb_driven  <= 1'b0;
         s_reg.pin0_prev  <= 1'b0;
         s_reg.edge_flag  <= 1'b0;
      end
      else
         s_reg <= s_next;
   end

   // ****************************************
   // pin drive and outputs
   // ****************************************
   pin_drive
   #(
      .WIDTH (4),
      .STYLE ({2'h0, OUT_STYLE})
   )
   u_out_drive
   (
      .latch      (s_reg.out_latch),
      .driven     (s_reg.out_driven),
      .pin_out    (out_unused_out),
      .pin_oe     (out_unused_oe),
      .pull_up_en ()
   );

   // bit 3 of the output latch has no pin
   assign out_port_pins_out = out_unused_out[2:0];
   assign out_port_pins_oe  = out_unused_oe[2:0];

   pin_drive
   #(
      .WIDTH (4),
      .STYLE ({4{PA_STYLE}})
   )
   u_pa_drive
   (
      .latch      (s_reg.pa_latch),
      .driven     (s_reg.pa_driven),
      .pin_out    (bidir_port_a_pins_out),
      .pin_oe     (bidir_port_a_pins_oe),
      .pull_up_en (bidir_port_a_pull_up)
   );

   pin_drive
   #(
      .WIDTH (4),
      .STYLE ({4{PB_STYLE}})
   )
   u_pb_drive
   (
      .latch      (s_reg.pb_latch),
      .driven     (s_reg.pb_driven),
      .pin_out    (bidir_port_b_pins_out),
      .pin_oe     (bidir_port_b_pins_oe),
      .pull_up_en (bidir_port_b_pull_up)
   );

   assign dat_o              = s_reg.dat;
   assign ack_o              = (s_reg.bus == BUS_ACK);
   assign count_src_sel_hi   = s_reg.cm[1];
   assign count_src_sel_lo   = s_reg.cm[0];
   assign timer_count_clk    =
      (s_reg.cm == port_defs_type_pkg::CM_PIN_COUNT) & pins[0];
   assign edge_input_enable  = s_reg.sm[2];
   assign edge_test_input    = s_reg.sm[2] & pins[0];
   assign edge_request       = s_reg.edge_flag;
   assign serial_func_sel_hi = s_reg.sm[1];
   assign serial_func_sel_lo = s_reg.sm[0];
   assign serial_clk_in      = pins[1];
   assign serial_data_in     = pins[3];

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_ack_one_cycle: assert property (ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");
   a_ack_after_req: assert property (req && !ack_o |=> ack_o)
      else $error("request not acknowledged next cycle");
   a_in_read_acc: assert property (
      cmd_go && op == port_defs_type_pkg::OP_READ && s_reg.idx == SEL_IN
      |=> s_reg.acc == $past(pins))
      else $error("input read did not copy pins");
   a_pa_write_load: assert property (
      cmd_go && op == port_defs_type_pkg::OP_WRITE && s_reg.idx == SEL_PA
      |=> s_reg.pa_latch == $past(s_reg.acc) && s_reg.pa_driven)
      else $error("port a write did not load latch");
   a_read_keeps_latch: assert property (
      cmd_go && op == port_defs_type_pkg::OP_READ
      |=> $stable(s_reg.pa_latch) && $stable(s_reg.pb_latch)
          && $stable(s_reg.pa_driven) && $stable(s_reg.pb_driven))
      else $error("read disturbed a bidir latch");
   a_pp_keeps_drive: assert property (
      s_reg.pb_driven |=> s_reg.pb_driven[*3])
      else $error("driver released without reset");
   a_bit_set_only: assert property (
      cmd_go && op == port_defs_type_pkg::OP_SET && s_reg.idx[3:2] == BIT_PA
      |=> s_reg.pa_latch == ($past(s_reg.pa_latch) | $past(bit_mask)))
      else $error("bit set changed other bits");
   a_out_bit3_kept: assert property (
      cmd_go && op[1] && s_reg.idx[3:2] == BIT_OUT
      |=> s_reg.out_latch[3] == $past(s_reg.out_latch[3]))
      else $error("bit op reached unimplemented bit");
   a_count_route: assert property (
      s_reg.cm != port_defs_type_pkg::CM_PIN_COUNT |-> !timer_count_clk)
      else $error("pin routed to timer in wrong mode");
   a_edge_flag_set: assert property (
      s_reg.sm[2] && pin0_rise
      |=> edge_request)
      else $error("edge flag not set on rising edge");

endmodule // quasi_bidir_port_logic

// ===== ext_pin_model.sv
// far-side circuit of one four-pin port: device driver, pull-up, load
// assumes clk is the core clock; one instance per bidirectional port
`timescale 1ns/1ps

module ext_pin_model
(
   input  wire logic       clk,
   input  wire logic [3:0] pin_out,
   input  wire logic [3:0] pin_oe,
   input  wire logic [3:0] pull_up,
   input  wire logic [3:0] ext_en,
   input  wire logic [3:0] ext_val,
   output logic      [3:0] level
);
   logic [3:0] last_reg;

   // a floating pin toggles so no stale level can pass for a read
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         if (pin_oe[i])
            level[i] = pin_out[i];
         else if (ext_en[i])
            level[i] = ext_val[i];
         else if (pull_up[i])
            level[i] = 1'b1;
         else
            level[i] = (last_reg[i] === 1'b1) ? 1'b0 : 1'b1;
      end
   end

   always_ff @(posedge clk)
      last_reg <= level;
endmodule // ext_pin_model

// ===== tb_top.sv
// self-checking bench for the port logic block
// assumes default parameters: out port and port b push-pull, port a od+pu
`timescale 1ns/1ps

module tb_top;
   typedef struct packed
   {
      logic [3:0]  idx;
      logic [1:0]  opc;
      logic [3:0]  acc;
      logic [17:0] exp;
   } row_type;

   logic                           clk;
   logic                           rst;
   port_defs_type_pkg::wb_req_type wb_req;
   port_defs_type_pkg::in_port_type in_port;
   logic [31:0] dat_o, q;
   logic        ack_o, tclk, cs_hi, cs_lo, e_en, e_in, e_req, s_hi, s_lo;
   logic        sck, sdi;
   logic [2:0]  o_out, o_oe;
   logic [3:0]  a_in, a_out, a_oe, a_pu, b_in, b_out, b_oe, b_pu;
   logic [3:0]  a_en, a_val;
   int          failures, n_compared;
   row_type     rows [11];

   quasi_bidir_port_logic uut (.clk(clk), .rst(rst), .wb_req(wb_req),
      .dat_o(dat_o), .ack_o(ack_o), .in_port(in_port),
      .out_port_pins_out(o_out), .out_port_pins_oe(o_oe),
      .bidir_port_a_pins_in(a_in), .bidir_port_a_pins_out(a_out),
      .bidir_port_a_pins_oe(a_oe), .bidir_port_a_pull_up(a_pu),
      .bidir_port_b_pins_in(b_in), .bidir_port_b_pins_out(b_out),
      .bidir_port_b_pins_oe(b_oe), .bidir_port_b_pull_up(b_pu),
      .timer_count_clk(tclk), .count_src_sel_hi(cs_hi),
      .count_src_sel_lo(cs_lo), .edge_input_enable(e_en),
      .edge_test_input(e_in), .edge_request(e_req),
      .serial_func_sel_hi(s_hi), .serial_func_sel_lo(s_lo),
      .serial_clk_in(sck), .serial_data_in(sdi));
   ext_pin_model pa (.clk(clk), .pin_out(a_out), .pin_oe(a_oe),
      .pull_up(a_pu), .ext_en(a_en), .ext_val(a_val), .level(a_in));
   ext_pin_model pb (.clk(clk), .pin_out(b_out), .pin_oe(b_oe),
      .pull_up(b_pu), .ext_en(4'h0), .ext_val(4'h0), .level(b_in));

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // ********************************
   // classic wishbone master cycle
   // ********************************
   task automatic wb(input logic wr, input logic [7:0] adr,
      input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      wb_req <= '{cyc:1'b1, stb:1'b1, we:wr, adr:adr, sel:4'hf, dat:d};
      // ack and read data are taken at the rising edge that commits
      do
      begin
         @(posedge clk);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      if (ack_o !== 1'b1)
         failures++;
      r = dat_o;
      wb_req <= '0;
      @(posedge clk);
   endtask

   task automatic op(input logic [3:0] idx, input logic [1:0] opc,
      input logic [3:0] acc);
      wb(1'b1, port_defs_type_pkg::OFS_INDEX, {28'h0, idx}, q);
      wb(1'b1, port_defs_type_pkg::OFS_ACC, {28'h0, acc}, q);
      wb(1'b1, port_defs_type_pkg::OFS_CMD, {30'h0, opc}, q);
   endtask

   task automatic summarize;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      #100000;
      failures++;
      summarize();
   end

   initial
   begin
      // exp: out pins, out oe, port a oe, port b pins, port b oe
      rows[0]  = '{4'h8, 2'h1, 4'h5, {3'h5, 3'h7, 4'h0, 4'h0, 4'h0}};
      rows[1]  = '{4'h1, 2'h2, 4'h0, {3'h7, 3'h7, 4'h0, 4'h0, 4'h0}};
      rows[2]  = '{4'h0, 2'h3, 4'h0, {3'h6, 3'h7, 4'h0, 4'h0, 4'h0}};
      rows[3]  = '{4'ha, 2'h1, 4'h3, {3'h6, 3'h7, 4'hc, 4'h0, 4'h0}};
      rows[4]  = '{4'hb, 2'h2, 4'h0, {3'h6, 3'h7, 4'h4, 4'h0, 4'h0}};
      rows[5]  = '{4'h8, 2'h3, 4'h0, {3'h6, 3'h7, 4'h5, 4'h0, 4'h0}};
      rows[6]  = '{4'ha, 2'h0, 4'h0, {3'h6, 3'h7, 4'h5, 4'h0, 4'h0}};
      rows[7]  = '{4'hb, 2'h1, 4'h9, {3'h6, 3'h7, 4'h5, 4'h9, 4'hf}};
      rows[8]  = '{4'hd, 2'h2, 4'h0, {3'h6, 3'h7, 4'h5, 4'hb, 4'hf}};
      rows[9]  = '{4'hf, 2'h3, 4'h0, {3'h6, 3'h7, 4'h5, 4'h3, 4'hf}};
      rows[10] = '{4'h8, 2'h1, 4'h0, {3'h0, 3'h7, 4'h5, 4'h3, 4'hf}};
      failures = 0;
      n_compared = 0;
      rst = 1'b1;
      wb_req = '0;
      in_port = '0;
      a_en = 4'h0;
      a_val = 4'h0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk({ack_o, o_oe, a_oe, b_oe, a_pu}, 32'h0000000f);
      chk(dat_o, 32'h0);
      @(posedge clk);
      foreach (rows[i])
      begin
         op(rows[i].idx, rows[i].opc, rows[i].acc);
         chk({o_out, o_oe, a_oe, b_out, b_oe}, rows[i].exp);
      end
      // set on the pinless bit 3 must leave the latch at zero
      op(4'h3, 2'h2, 4'h0);
      op(4'h8, 2'h0, 4'h0);
      wb(1'b0, port_defs_type_pkg::OFS_ACC, 32'h0, q);
      chk(q, 32'h0);
      // ********************************
      // awkward cases
      // ********************************
      a_en <= 4'h8; // load pulls released bit 3 low
      in_port <= 4'h6;
      op(4'ha, 2'h0, 4'h0);
      wb(1'b0, port_defs_type_pkg::OFS_ACC, 32'h0, q);
      chk(q, 32'h2);
      op(4'hb, 2'h0, 4'h0);
      wb(1'b0, port_defs_type_pkg::OFS_ACC, 32'h0, q);
      chk(q, 32'h3);
      op(4'h0, 2'h0, 4'h0);
      wb(1'b0, port_defs_type_pkg::OFS_ACC, 32'h0, q);
      chk(q, 32'h6);
      chk({sck, sdi, a_out, b_pu}, 32'h200);
      wb(1'b0, port_defs_type_pkg::OFS_PINS, 32'h0, q);
      chk(q, 32'h326);
      op(4'h1, 2'h1, 4'h2);
      in_port <= 4'h7;
      @(negedge clk);
      chk({cs_hi, cs_lo, tclk}, 32'h3);
      @(posedge clk);
      op(4'h1, 2'h1, 4'h4);
      chk({cs_hi, cs_lo, tclk}, 32'h4);
      op(4'h2, 2'h1, 4'he);
      in_port <= 4'h0;
      chk({e_en, s_hi, s_lo, e_req}, 32'he);
      @(posedge clk);
      in_port <= 4'h1;
      repeat (2) @(negedge clk);
      chk({e_in, e_req}, 32'h3);
      @(posedge clk);
      wb(1'b0, port_defs_type_pkg::OFS_STATUS, 32'h0, q);
      chk(q, 32'h1);
      wb(1'b1, port_defs_type_pkg::OFS_STATUS, 32'h1, q);
      wb(1'b0, port_defs_type_pkg::OFS_STATUS, 32'h0, q);
      chk(q, 32'h0);
      wb(1'b0, 8'h20, 32'h0, q);
      chk(q, 32'h0);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk({o_oe, a_oe, b_oe, b_out, e_req}, 32'h0);
      summarize();
   end
endmodule // tb_top
